// ===== hdl/cisc_defs.vh
// Register offsets, field positions, reset values and timing for snoop control
`ifndef CISC_DEFS_VH
`define CISC_DEFS_VH

// Register indices (byte address = index * 4)
`define CISC_IDX_RING_THR 8'h0e
`define CISC_IDX_MON_GAIN 8'h10
`define CISC_IDX_HOOK 8'h12
`define CISC_IDX_DC_MASK 8'h13
`define CISC_IDX_SIG_SNOOP 8'h14
`define CISC_IDX_RING_SNOOP 8'h15
`define CISC_IDX_PATH_EN 8'h16
`define CISC_IDX_AC_TERM 8'h17
`define CISC_IDX_STATUS 8'h20
`define CISC_IDX_FRAME 8'h21

// Field positions
`define CISC_HOOK_SWITCH 7
`define CISC_DC_LOOP_ON 6
`define CISC_AC_LOOP_ON 5
`define CISC_SHUNT_LOAD_ON 4
`define CISC_SIG_SNOOP_BIT 4
`define CISC_SIG_BOOST_BIT 3
`define CISC_RING_SNOOP_BIT 4
`define CISC_RING_BOOST_BIT 5
`define CISC_TX_ON_BIT 7
`define CISC_RX_EN_BIT 6
`define CISC_RLOOP_BIT 5
`define CISC_ATTEN_BIT 4
`define CISC_FSYNC_HI 3
`define CISC_FSYNC_LO 0
`define CISC_ACZ_HI 4
`define CISC_ACZ_LO 3
`define CISC_DC_MASK_SELECT_HI 7
`define CISC_DC_MASK_SELECT_LO 6
`define CISC_RGTH_HI 1
`define CISC_RGTH_LO 0

// Reset values
`define CISC_RST_REG 8'h00

// Auxiliary sample refresh
`define CISC_AUX_REFRESH_US 400
`define CISC_CLK_MHZ 40

`endif

// ===== hdl/cisc_aux_tick.v
// Periodic refresh strobe for the auxiliary sample registers
`timescale 1ns/10ps
module cisc_aux_tick #(
    parameter CYCLES = 16000
)
(
    // Clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_ce,
    // Strobe
    output reg o_tick
);

reg [23:0] cnt_q;

always @(posedge i_mclk)
begin
    if (!i_rst_n)
    begin
        cnt_q <= 24'h000000;
        o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
        if (cnt_q == CYCLES[23:0] - 24'h000001)
        begin
            cnt_q <= 24'h000000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 24'h000001;
            o_tick <= 1'b0;
        end
    end
end

endmodule // cisc_aux_tick

// ===== hdl/cisc_snoop_ctrl.v
// Caller-ID snoop control register bank with APB and control-frame writes
// Operation
// - 0x16 bit 6 enables receive path
// - 0x14 bit 4 selects receive-pin snoop
// - 0x14 bit 3 adds caller-ID receive gain
// - 0x15 bit 4 selects ring-detector snoop
// - 0x15 bit 5 inserts 20 dB ring gain
// - Monitor gain register sets tx/rx gains
// - Alarm tone only while modem idle
// - 0x17 bits 4:3 select AC termination
// - 0x13 bits 7:6 select DC mask
// - 0x0E bits 1:0 set ring threshold
// - Global settings writable at any time
// - 0x16 holds path enables and sync
// - Aux samples refresh every 400 us
`timescale 1ns/10ps
`include "cisc_defs.vh"
module cisc_snoop_ctrl #(
    parameter AUX_CYCLES = `CISC_AUX_REFRESH_US * `CISC_CLK_MHZ
)
(
    // Clock, reset, enable
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_ce,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Control frames from the serial port
    input wire i_frame_valid,
    input wire i_frame_is_ctrl,
    input wire [15:0] i_frame_word,
    // Modem activity, alarm request, aux samples
    input wire i_modem_active,
    input wire i_alarm_req,
    input wire [7:0] i_ring_sample,
    input wire [7:0] i_line_sample,
    // Path controls
    output reg o_receive_path_enable,
    output reg o_transmit_path_on,
    output reg o_remote_loopback_on,
    output reg o_attenuation_on,
    output reg [3:0] o_frame_sync_control,
    output reg o_signal_path_snoop,
    output reg o_signal_snoop_boost,
    output reg o_ring_path_snoop,
    output reg o_ring_snoop_boost,
    output reg [7:0] o_monitor_gain,
    output reg o_hook_switch,
    output reg o_dc_loop_on,
    output reg o_ac_loop_on,
    output reg o_shunt_load_on,
    output reg [1:0] o_ac_termination_select,
    output reg [1:0] o_dc_mask_select,
    output reg [1:0] o_ring_threshold_select,
    output reg o_alarm_tone_on,
    output reg [7:0] o_ring_sample,
    output reg [7:0] o_line_sample
);

////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] ring_thr_q;
reg [7:0] mon_gain_q;
reg [7:0] hook_q;
reg [7:0] dc_mask_q;
reg [7:0] sig_snoop_q;
reg [7:0] ring_snoop_q;
reg [7:0] path_en_q;
reg [7:0] ac_term_q;
reg frame_seen_q;
// Two-stage synchronisers for the modem and alarm pins
reg modem_s1_q;
reg modem_s2_q;
reg alarm_s1_q;
reg alarm_s2_q;
wire aux_tick;

// Bus and frame write strobes with their decoded indices
wire apb_wr = i_psel && i_penable && i_pwrite && !o_pready;
wire apb_rd = i_psel && i_penable && !i_pwrite && !o_pready;
wire [7:0] apb_idx = i_paddr[9:2];
wire frm_wr = i_frame_valid && i_frame_is_ctrl;
wire [7:0] frm_idx = i_frame_word[15:8];
wire [7:0] frm_dat = i_frame_word[7:0];

// Only aligned words with the top two address bits clear are mapped
reg idx_ok;
always @*
begin
    case (apb_idx)
        `CISC_IDX_RING_THR, `CISC_IDX_MON_GAIN, `CISC_IDX_HOOK,
        `CISC_IDX_DC_MASK, `CISC_IDX_SIG_SNOOP, `CISC_IDX_RING_SNOOP,
        `CISC_IDX_PATH_EN, `CISC_IDX_AC_TERM, `CISC_IDX_STATUS,
        `CISC_IDX_FRAME: idx_ok = (i_paddr[1:0] == 2'h0) &&
            (i_paddr[11:10] == 2'h0);
        default: idx_ok = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// Register writes; a control frame wins over APB on the same register
always @(posedge i_mclk)
begin
    if (!i_rst_n)
    begin
        ring_thr_q <= `CISC_RST_REG;
        mon_gain_q <= `CISC_RST_REG;
        hook_q <= `CISC_RST_REG;
        dc_mask_q <= `CISC_RST_REG;
        sig_snoop_q <= `CISC_RST_REG;
        ring_snoop_q <= `CISC_RST_REG;
        path_en_q <= `CISC_RST_REG;
        ac_term_q <= `CISC_RST_REG;
        frame_seen_q <= 1'b0;
    end
    else if (i_ce)
    begin
        if (apb_wr && idx_ok)
        begin
            case (apb_idx)
                `CISC_IDX_RING_THR: ring_thr_q <= i_pwdata[7:0];
                `CISC_IDX_MON_GAIN: mon_gain_q <= i_pwdata[7:0];
                `CISC_IDX_HOOK: hook_q <= i_pwdata[7:0];
                `CISC_IDX_DC_MASK: dc_mask_q <= i_pwdata[7:0];
                `CISC_IDX_SIG_SNOOP: sig_snoop_q <= i_pwdata[7:0];
                `CISC_IDX_RING_SNOOP: ring_snoop_q <= i_pwdata[7:0];
                `CISC_IDX_PATH_EN: path_en_q <= i_pwdata[7:0];
                `CISC_IDX_AC_TERM: ac_term_q <= i_pwdata[7:0];
                `CISC_IDX_FRAME: frame_seen_q <= 1'b0;
                default: ;
            endcase
        end
        // Issued after the bus write so that a frame wins on one register
        if (frm_wr)
        begin
            frame_seen_q <= 1'b1;
            case (frm_idx)
                `CISC_IDX_RING_THR: ring_thr_q <= frm_dat;
                `CISC_IDX_MON_GAIN: mon_gain_q <= frm_dat;
                `CISC_IDX_HOOK: hook_q <= frm_dat;
                `CISC_IDX_DC_MASK: dc_mask_q <= frm_dat;
                `CISC_IDX_SIG_SNOOP: sig_snoop_q <= frm_dat;
                `CISC_IDX_RING_SNOOP: ring_snoop_q <= frm_dat;
                `CISC_IDX_PATH_EN: path_en_q <= frm_dat;
                `CISC_IDX_AC_TERM: ac_term_q <= frm_dat;
                default: ;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// APB answer: one wait state, every access answered next cycle
always @(posedge i_mclk)
begin
    if (!i_rst_n)
    begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
        o_prdata <= 32'h00000000;
    end
    else if (i_ce)
    begin
        o_pready <= i_psel && i_penable && !o_pready;
        o_pslverr <= (apb_wr || apb_rd) && !idx_ok;
        o_prdata <= 32'h00000000;
        if (apb_rd && idx_ok)
        begin
            case (apb_idx)
                `CISC_IDX_RING_THR: o_prdata[7:0] <= ring_thr_q;
                `CISC_IDX_MON_GAIN: o_prdata[7:0] <= mon_gain_q;
                `CISC_IDX_HOOK: o_prdata[7:0] <= hook_q;
                `CISC_IDX_DC_MASK: o_prdata[7:0] <= dc_mask_q;
                `CISC_IDX_SIG_SNOOP: o_prdata[7:0] <= sig_snoop_q;
                `CISC_IDX_RING_SNOOP: o_prdata[7:0] <= ring_snoop_q;
                `CISC_IDX_PATH_EN: o_prdata[7:0] <= path_en_q;
                `CISC_IDX_AC_TERM: o_prdata[7:0] <= ac_term_q;
                `CISC_IDX_STATUS:
                begin
                    o_prdata[7] <= modem_s2_q;
                    o_prdata[6] <= o_alarm_tone_on;
                    o_prdata[5] <= o_receive_path_enable;
                    o_prdata[4] <= o_signal_path_snoop;
                    o_prdata[3] <= o_ring_path_snoop;
                    o_prdata[2] <= frame_seen_q;
                end
                `CISC_IDX_FRAME: o_prdata[15:0] <= {o_ring_sample,
                    o_line_sample};
                default: ;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
// Only the second stage of each pair is read by logic
always @(posedge i_mclk)
begin
    if (!i_rst_n)
    begin
        modem_s1_q <= 1'b0;
        modem_s2_q <= 1'b0;
        alarm_s1_q <= 1'b0;
        alarm_s2_q <= 1'b0;
    end
    else if (i_ce)
    begin
        modem_s1_q <= i_modem_active;
        modem_s2_q <= modem_s1_q;
        alarm_s1_q <= i_alarm_req;
        alarm_s2_q <= alarm_s1_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// Auxiliary sample refresh
// Held samples change at most once per refresh strobe
cisc_aux_tick #(
    .CYCLES(AUX_CYCLES)
) u_tick (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .o_tick(aux_tick)
);

////////////////////////////////////////////////////////////////////////////
// Registered control outputs
always @(posedge i_mclk)
begin
    if (!i_rst_n)
    begin
        o_receive_path_enable <= 1'b0;
        o_transmit_path_on <= 1'b0;
        o_remote_loopback_on <= 1'b0;
        o_attenuation_on <= 1'b0;
        o_frame_sync_control <= 4'h0;
        o_signal_path_snoop <= 1'b0;
        o_signal_snoop_boost <= 1'b0;
        o_ring_path_snoop <= 1'b0;
        o_ring_snoop_boost <= 1'b0;
        o_monitor_gain <= 8'h00;
        o_hook_switch <= 1'b0;
        o_dc_loop_on <= 1'b0;
        o_ac_loop_on <= 1'b0;
        o_shunt_load_on <= 1'b0;
        o_ac_termination_select <= 2'h0;
        o_dc_mask_select <= 2'h0;
        o_ring_threshold_select <= 2'h0;
        o_alarm_tone_on <= 1'b0;
        o_ring_sample <= 8'h00;
        o_line_sample <= 8'h00;
    end
    else if (i_ce)
    begin
        // Path enables and frame sync
        o_receive_path_enable <= path_en_q[`CISC_RX_EN_BIT];
        o_transmit_path_on <= path_en_q[`CISC_TX_ON_BIT];
        o_remote_loopback_on <= path_en_q[`CISC_RLOOP_BIT];
        o_attenuation_on <= path_en_q[`CISC_ATTEN_BIT];
        o_frame_sync_control <=
            path_en_q[`CISC_FSYNC_HI:`CISC_FSYNC_LO];
        // Snoop paths and their gains
        o_signal_path_snoop <= sig_snoop_q[`CISC_SIG_SNOOP_BIT];
        o_signal_snoop_boost <= sig_snoop_q[`CISC_SIG_BOOST_BIT];
        o_ring_path_snoop <= ring_snoop_q[`CISC_RING_SNOOP_BIT];
        o_ring_snoop_boost <= ring_snoop_q[`CISC_RING_BOOST_BIT];
        o_monitor_gain <= mon_gain_q;
        // Hook controls pass through; the host chooses the combination
        o_hook_switch <= hook_q[`CISC_HOOK_SWITCH];
        o_dc_loop_on <= hook_q[`CISC_DC_LOOP_ON];
        o_ac_loop_on <= hook_q[`CISC_AC_LOOP_ON];
        o_shunt_load_on <= hook_q[`CISC_SHUNT_LOAD_ON];
        // Global line settings, changeable at any time
        o_ac_termination_select <=
            ac_term_q[`CISC_ACZ_HI:`CISC_ACZ_LO];
        o_dc_mask_select <= dc_mask_q[`CISC_DC_MASK_SELECT_HI:`CISC_DC_MASK_SELECT_LO];
        o_ring_threshold_select <=
            ring_thr_q[`CISC_RGTH_HI:`CISC_RGTH_LO];
        // The tone is held off whenever the modem is busy
        o_alarm_tone_on <= alarm_s2_q && !modem_s2_q;
        if (aux_tick)
        begin
            o_ring_sample <= i_ring_sample;
            o_line_sample <= i_line_sample;
        end
    end
end

endmodule // cisc_snoop_ctrl

// ===== bench/cisc_host_model.sv
// Host model that writes registers through alternating serial-port frames
`timescale 1ns/10ps
module cisc_host_model (
    // Clock, reset, write request
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic [15:0] i_word,
    // Frame to the device
    output logic o_frame_valid = 1'b0,
    output logic o_frame_is_ctrl = 1'b0,
    output logic [15:0] o_frame_word = 16'h0
);
logic data_q = 1'b0;
// A data frame with inverted data follows each control frame
always @(posedge i_mclk)
begin
    data_q <= i_req & i_rst_n;
    o_frame_valid <= (i_req | data_q) & i_rst_n;
    o_frame_is_ctrl <= i_req;
    o_frame_word <= i_req ? i_word : ~o_frame_word ^ 16'hff00;
end
endmodule // cisc_host_model

// ===== bench/cisc_snoop_ctrl_sva.sv
// Checker for register fields and the tone output of the snoop control bank
`timescale 1ns/10ps
module cisc_snoop_ctrl_sva (
    // Clock, reset, APB
    input wire logic i_mclk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    // Frames and modem state
    input wire logic i_frame_valid, i_frame_is_ctrl, i_modem_active,
    input wire logic [15:0] i_frame_word,
    // Controls
    input wire logic o_receive_path_enable, o_alarm_tone_on,
    input wire logic o_signal_path_snoop, o_signal_snoop_boost,
    input wire logic o_ring_path_snoop, o_ring_snoop_boost,
    input wire logic [7:0] o_monitor_gain,
    input wire logic [1:0] o_ac_termination_select, o_dc_mask_select,
    input wire logic [1:0] o_ring_threshold_select
);
default clocking @(posedge i_mclk); endclocking
default disable iff (!i_rst_n);
wire aw = i_psel & i_penable & o_pready & i_pwrite;
wire fw = i_frame_valid & i_frame_is_ctrl;
wire [7:0] fi = i_frame_word[15:8];
////////////////////////////////////////////////////////////////////////////
property p_rx;
    aw && i_paddr == 12'h058 |=> o_receive_path_enable == $past(i_pwdata[6]);
endproperty
a_rx: assert property (p_rx) else $error("receive enable wrong");
property p_sig;
    fw && fi == 8'h14 |-> ##2 {o_signal_path_snoop, o_signal_snoop_boost}
        == $past(i_frame_word[4:3], 2);
endproperty
a_sig: assert property (p_sig)
    else $error("signal snoop wrong");
property p_ring;
    aw && i_paddr == 12'h054 |=> {o_ring_snoop_boost, o_ring_path_snoop}
        == $past(i_pwdata[5:4]);
endproperty
a_ring: assert property (p_ring)
    else $error("ring snoop wrong");
property p_mon;
    aw && i_paddr == 12'h040 |=> o_monitor_gain == $past(i_pwdata[7:0]);
endproperty
a_mon: assert property (p_mon) else $error("monitor gain wrong");
property p_acz;
    aw && i_paddr == 12'h05c |=>
        o_ac_termination_select == $past(i_pwdata[4:3]);
endproperty
a_acz: assert property (p_acz)
    else $error("termination wrong");
property p_dc_mask_select;
    fw && fi == 8'h13 |-> ##2 o_dc_mask_select == $past(i_frame_word[7:6], 2);
endproperty
a_dc_mask_select: assert property (p_dc_mask_select) else $error("dc mask wrong");
property p_rgth;
    aw && i_paddr == 12'h038 |=>
        o_ring_threshold_select == $past(i_pwdata[1:0]);
endproperty
a_rgth: assert property (p_rgth)
    else $error("ring threshold wrong");
property p_idle;
    i_modem_active [*3] |=> !o_alarm_tone_on;
endproperty
a_idle: assert property (p_idle) else $error("tone while active");
c_apb: cover property (aw);
c_frame: cover property (fw && fi == 8'h16);
c_tone: cover property (o_alarm_tone_on);
endmodule // cisc_snoop_ctrl_sva
bind cisc_snoop_ctrl cisc_snoop_ctrl_sva u_sva (.i_mclk, .i_rst_n, .i_psel,
    .i_penable, .i_pwrite, .o_pready, .i_paddr, .i_pwdata, .i_frame_valid,
    .i_frame_is_ctrl, .i_modem_active, .i_frame_word, .o_receive_path_enable,
    .o_alarm_tone_on, .o_signal_path_snoop, .o_signal_snoop_boost,
    .o_ring_path_snoop, .o_ring_snoop_boost, .o_monitor_gain,
    .o_ac_termination_select, .o_dc_mask_select, .o_ring_threshold_select);

// ===== bench/tb.sv
// Testbench: snoop control bank against a reference register model
`timescale 1ns/10ps
module tb;
logic i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_psel = 1'b0, err;
logic i_penable = 1'b0, i_pwrite = 1'b0, req = 1'b0;
logic i_modem_active = 1'b0, i_alarm_req = 1'b0;
logic [11:0] i_paddr = 12'h0;
logic [31:0] i_pwdata = 32'h0, rd, o_prdata, seed = 32'h4964;
logic [15:0] word = 16'h0, i_frame_word;
logic [7:0] i_ring_sample = 8'h0, i_line_sample = 8'h0, rf [0:255];
logic i_frame_valid, i_frame_is_ctrl, o_pready, o_pslverr, o_alarm_tone_on;
logic o_transmit_path_on, o_receive_path_enable, o_remote_loopback_on;
logic o_attenuation_on, o_signal_path_snoop, o_signal_snoop_boost;
logic o_ring_path_snoop, o_ring_snoop_boost, o_hook_switch, o_dc_loop_on;
logic o_ac_loop_on, o_shunt_load_on;
logic [3:0] o_frame_sync_control;
logic [1:0] o_ac_termination_select, o_dc_mask_select, o_ring_threshold_select;
logic [7:0] o_monitor_gain, o_ring_sample, o_line_sample;
logic [7:0] keep;
logic [7:0] ix [0:7] = '{8'h0e, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h17};
logic [15:0] seq [0:18] = '{16'h1204, 16'h1310, 16'h1420, 16'h1508, 16'h16d0,
    16'h1700, 16'h0e02, 16'h1055,
    16'h1640, 16'h1400, 16'h1530, 16'h1500, 16'h1600,
    16'h1280, 16'h1640, 16'h1500, 16'h1418,
    16'h1400, 16'h1600};
int errors = 0, samples_checked = 0;
cisc_snoop_ctrl #(.AUX_CYCLES(8)) uut (.i_mclk, .i_rst_n, .i_ce, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_frame_valid, .i_frame_is_ctrl, .i_frame_word,
    .i_modem_active, .i_alarm_req, .i_ring_sample, .i_line_sample,
    .o_receive_path_enable, .o_transmit_path_on, .o_remote_loopback_on,
    .o_attenuation_on, .o_frame_sync_control, .o_signal_path_snoop,
    .o_signal_snoop_boost, .o_ring_path_snoop, .o_ring_snoop_boost,
    .o_monitor_gain, .o_hook_switch, .o_dc_loop_on, .o_ac_loop_on,
    .o_shunt_load_on, .o_ac_termination_select, .o_dc_mask_select,
    .o_ring_threshold_select, .o_alarm_tone_on, .o_ring_sample,
    .o_line_sample);
cisc_host_model host (.i_mclk, .i_rst_n, .i_req(req), .i_word(word),
    .o_frame_valid(i_frame_valid), .o_frame_is_ctrl(i_frame_is_ctrl),
    .o_frame_word(i_frame_word));
////////////////////////////////////////////////////////////////////////////
function logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
        errors++;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
endtask
task stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1)
        @(posedge i_mclk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
endtask
task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, {24'h0, d});
    rf[i] = d;
    repeat (2) @(posedge i_mclk);
endtask
task hw(input logic [15:0] w);
    @(posedge i_mclk);
    req <= 1'b1;
    word <= w;
    @(posedge i_mclk);
    req <= 1'b0;
    repeat (4) @(posedge i_mclk);
    rf[w[15:8]] = w[7:0];
endtask
task co();
    chk("outs", {2'b00, o_transmit_path_on, o_receive_path_enable,
        o_remote_loopback_on, o_attenuation_on, o_frame_sync_control,
        o_signal_path_snoop, o_signal_snoop_boost, o_ring_snoop_boost,
        o_ring_path_snoop, o_monitor_gain, o_hook_switch, o_dc_loop_on,
        o_ac_loop_on, o_shunt_load_on, o_ac_termination_select,
        o_dc_mask_select, o_ring_threshold_select}, {2'b00, rf[8'h16],
        rf[8'h14][4:3], rf[8'h15][5:4], rf[8'h10], rf[8'h12][7:4],
        rf[8'h17][4:3], rf[8'h13][7:6], rf[8'h0e][1:0]});
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    forever #12.5 i_mclk = ~i_mclk;
end
// Watchdog: about 80000 clocks, far beyond the whole run
initial
begin
    #2000000;
    errors++;
    stop_test();
end
initial
begin
    foreach (rf[k]) rf[k] = 8'h00;
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    foreach (ix[k])
    begin
        apb(1'b0, {2'b00, ix[k], 2'b00}, 32'h0);
        chk("reset", rd, 32'h0);
    end
    co();
    $display("reset test done");
    foreach (seq[k])
    begin
        if (k % 2)
            wr(seq[k][15:8], seq[k][7:0]);
        else
            hw(seq[k]);
        co();
    end
    $display("sequence test done");
    repeat (24)
    begin
        seed = lf(seed);
        wr(ix[seed[10:8]], seed[7:0]);
        co();
        apb(1'b0, {2'b00, ix[seed[10:8]], 2'b00}, 32'h0);
        chk("readback", rd, {24'h0, rf[ix[seed[10:8]]]});
    end
    // Every register once by frame and once by bus
    foreach (ix[k])
    begin
        seed = lf(seed);
        hw({ix[k], seed[7:0]});
        co();
        wr(ix[k], seed[15:8]);
        co();
    end
    apb(1'b1, 12'h03c, 32'hff);
    chk("slverr", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h03c, 32'h0);
    chk("unmapped", rd, 32'h0);
    co();
    $display("register test done");
    // A frame while the clock enable is low must change nothing
    keep = rf[8'h10];
    i_ce <= 1'b0;
    hw({8'h10, ~keep});
    i_ce <= 1'b1;
    rf[8'h10] = keep;
    repeat (2) @(posedge i_mclk);
    co();
    $display("clock enable test done");
    i_alarm_req <= 1'b1;
    repeat (5) @(posedge i_mclk);
    chk("tone_idle", {31'h0, o_alarm_tone_on}, 32'h1);
    i_modem_active <= 1'b1;
    repeat (5) @(posedge i_mclk);
    chk("tone_busy", {31'h0, o_alarm_tone_on}, 32'h0);
    apb(1'b0, 12'h080, 32'h0);
    chk("status", rd, {24'h0, 2'b10, rf[8'h16][6], rf[8'h14][4],
        rf[8'h15][4], 3'h4});
    apb(1'b1, 12'h084, 32'h0);
    apb(1'b0, 12'h080, 32'h0);
    chk("seen_clear", {31'h0, rd[2]}, 32'h0);
    seed = lf(seed);
    i_ring_sample <= seed[7:0];
    i_line_sample <= seed[15:8];
    repeat (20) @(posedge i_mclk);
    apb(1'b0, 12'h084, 32'h0);
    chk("samples", rd, {16'h0, seed[7:0], seed[15:8]});
    chk("ring_out", {24'h0, o_ring_sample}, {24'h0, seed[7:0]});
    chk("line_out", {24'h0, o_line_sample}, {24'h0, seed[15:8]});
    $display("tone and sample test done");
    stop_test();
end
endmodule // tb
